// ===== design/pom_phase_offset_measure.sv
// Phase offset measurement between two selectable channel signals.
// Assumes sources and control strobes are synchronous to clk_i.
`timescale 1ns/1ns
module pom_phase_offset_measure
  import pom_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    arst_n_i,
  input  wire logic [POM_NUM_SRC-1:0]  src_vec_i,
  input  wire logic [POM_NUM_TB-1:0]   tb_src_i,
  input  wire logic [POM_SEL_W-1:0]    first_signal_select_i,
  input  wire logic [POM_SEL_W-1:0]    second_signal_select_i,
  input  wire logic [POM_TB_SEL_W-1:0] timebase_select_i,
  input  wire logic                    second_edge_invert_i,
  input  wire logic                    start_i,
  input  wire logic                    offset_count_reset_i,
  input  wire logic                    ready_clear_i,
  input  wire logic                    overflow_clear_i,
  output logic                         busy_o,
  output logic                         result_ready_latched_o,
  output logic                         overflow_latched_o,
  output logic [POM_RES_W-1:0]         offset_count_o,
  output logic [POM_CORR_W-1:0]        offset_correction_o
);

  function automatic logic is_output(input logic [POM_SEL_W-1:0] sel);
    return (sel >= POM_SEL_W'(POM_OUT_BASE)) &&
           (sel <  POM_SEL_W'(POM_OUT_BASE + POM_NUM_OUT));
  endfunction

  pom_state_t           state_q;
  logic                 a_q, b_q, tb_q;
  logic                 a_prev_q, b_prev_q, tb_prev_q;
  logic [10:0]          fwd_q, since_b_q;
  logic                 sb_valid_q;
  logic                 tick, a_edge, b_edge, done, ovf_evt;
  logic [10:0]          result;

  // Registered source muxes
  // One cycle of latency, the same for A, B and timebase,
  // so their relative timing is kept
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      a_q  <= 1'b0;
      b_q  <= 1'b0;
      tb_q <= 1'b0;
    end else begin
      a_q  <= src_vec_i[first_signal_select_i]; // RULE1
      b_q  <= src_vec_i[second_signal_select_i] ^ second_edge_invert_i; // RULE1 RULE10
      tb_q <= (timebase_select_i < POM_TB_SEL_W'(POM_NUM_TB)) ?
              tb_src_i[timebase_select_i] : 1'b0; // RULE2
    end
  end

  // Sampling on timebase rising edge
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tb_prev_q <= 1'b0;
      a_prev_q  <= 1'b0;
      b_prev_q  <= 1'b0;
    end else begin
      tb_prev_q <= tb_q;
      if (tick) begin
        a_prev_q <= a_q; // RULE5
        b_prev_q <= b_q;
      end
    end
  end

  assign tick    = tb_q & ~tb_prev_q;
  assign a_edge  = tick & a_q & ~a_prev_q; // RULE5
  assign b_edge  = tick & b_q & ~b_prev_q; // RULE10
  // B edge on the A tick is ignored, so alignment yields one B period
  assign done    = (state_q == POM_COUNT) && b_edge && !offset_count_reset_i; // RULE9
  assign ovf_evt = (state_q == POM_COUNT) && tick && !b_edge &&
                   (fwd_q == POM_CNT_MAX) && !offset_count_reset_i; // RULE6 RULE16

  // Report the nearer edge: earlier B edge gives a negative count
  always_comb begin
    result = fwd_q;
    if (sb_valid_q && (since_b_q != POM_CNT_ZERO) && (since_b_q < fwd_q))
      result = 11'(~since_b_q + POM_CNT_ONE); // RULE8
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= POM_IDLE;
    end else if (offset_count_reset_i) begin
      state_q <= POM_IDLE; // RULE4
    end else begin
      unique case (state_q)
        POM_IDLE:   if (start_i) state_q <= POM_WAIT_A; // RULE3
        POM_WAIT_A: if (a_edge) state_q <= POM_COUNT;
        POM_COUNT:  if (done || ovf_evt) state_q <= POM_IDLE;
      endcase
    end
  end

  // Counters, cleared by each start from idle
  // Both counters are 11 bits; no longer counters are kept,
  // so slow B against a fast timebase ends in overflow
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fwd_q      <= POM_CNT_ZERO;
      since_b_q  <= POM_CNT_ZERO;
      sb_valid_q <= 1'b0;
    end else if (start_i && state_q == POM_IDLE) begin
      fwd_q      <= POM_CNT_ZERO; // RULE19
      since_b_q  <= POM_CNT_ZERO;
      sb_valid_q <= 1'b0;
    end else if (state_q == POM_WAIT_A) begin
      if (a_edge) fwd_q <= POM_CNT_ONE;
      if (b_edge) begin
        since_b_q  <= POM_CNT_ZERO;
        sb_valid_q <= 1'b1;
      end else if (tick && since_b_q != POM_CNT_MAX) begin
        // A tick counts too, so B three ticks early reads minus three
        since_b_q <= since_b_q + POM_CNT_ONE; // Saturates: old edges too far back
      end
    end else if (state_q == POM_COUNT && tick && !b_edge) begin
      fwd_q <= fwd_q + POM_CNT_ONE; // RULE5
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= !offset_count_reset_i && ((state_q == POM_IDLE && start_i) ||
                (state_q != POM_IDLE && !done && !ovf_evt)); // RULE7
    end
  end

  // Set wins over a simultaneous clear
  // Abort changes no flag
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result_ready_latched_o <= 1'b0;
      overflow_latched_o     <= 1'b0;
    end else begin
      if (done || ovf_evt)
        result_ready_latched_o <= 1'b1; // RULE7
      else if (ready_clear_i)
        result_ready_latched_o <= 1'b0; // RULE17
      if (ovf_evt)
        overflow_latched_o <= 1'b1; // RULE6 RULE19
      else if (overflow_clear_i)
        overflow_latched_o <= 1'b0; // RULE17
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      offset_count_o      <= POM_CNT_ZERO;
      offset_correction_o <= POM_CORR_NONE;
    end else if (done) begin
      offset_count_o <= result; // RULE6
      if (!is_output(first_signal_select_i) && is_output(second_signal_select_i))
        offset_correction_o <= POM_CORR_POS; // RULE12
      else if (is_output(first_signal_select_i) && !is_output(second_signal_select_i))
        offset_correction_o <= POM_CORR_NEG; // RULE13
      else
        offset_correction_o <= POM_CORR_NONE;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_start_idle;
    state_q == POM_IDLE && start_i && !offset_count_reset_i;
  endsequence
  sequence s_finish;
    done || ovf_evt;
  endsequence

  property p_start_busy;
    s_start_idle |=> busy_o && state_q == POM_WAIT_A;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start did not set busy"); // RULE3

  property p_abort_idle;
    offset_count_reset_i |=> !busy_o && state_q == POM_IDLE;
  endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("abort left logic running"); // RULE4

  property p_finish_flags;
    s_finish |=> !busy_o && result_ready_latched_o;
  endproperty
  a_finish_flags: assert property (p_finish_flags) else $error("finish flags wrong"); // RULE7

  property p_ovf_set;
    ovf_evt |=> overflow_latched_o;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not latched"); // RULE6

  property p_ovf_sticky;
    overflow_latched_o && !overflow_clear_i |=> overflow_latched_o;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow dropped alone"); // RULE19

  property p_rdy_clear;
    ready_clear_i && !done && !ovf_evt |=> !result_ready_latched_o;
  endproperty
  a_rdy_clear: assert property (p_rdy_clear) else $error("ready not cleared"); // RULE17

  property p_no_zero;
    done |=> offset_count_o != POM_CNT_ZERO;
  endproperty
  a_no_zero: assert property (p_no_zero) else $error("zero result reported"); // RULE9

  property p_busy_state;
    busy_o == (state_q != POM_IDLE);
  endproperty
  a_busy_state: assert property (p_busy_state) else $error("busy disagrees with state"); // RULE7

  property p_result_hold;
    !done |=> $stable(offset_count_o);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result moved without done"); // RULE6

endmodule

// ===== design/pom_pkg.sv
// Constants for the phase offset measurement block.
// Assumes one 100 MHz system clock; all source signals synchronous to it.
// Functional notes
// RULE1: Signals A and B each chosen independently from inputs, outputs or pins.
// RULE2: Timebase chosen from oscillator, doubled oscillator or three medium-speed dividers.
// RULE3: Start begins a measurement; software waits or aborts before next start.
// RULE4: Measurement reset aborts a running measurement and returns logic to idle.
// RULE5: Sample A and B on timebase, count timebase cycles from A edge to B edge.
// RULE6: Valid count goes to result field; overflow sets latched flag, result invalid.
// RULE7: Busy is 1 while measuring; on completion busy drops and ready latches.
// RULE8: Result is eleven-bit two's complement; negative means B edge before A.
// RULE9: Aligned within one timebase cycle reports one full B period, not zero.
// RULE10: B-invert bit makes the measurement use the opposite edge of B.
// RULE11: Software keeps B frequency an integer multiple of A frequency.
// RULE12: Pin A to output B: true offset is count plus six high-speed periods.
// RULE13: Output A to pin B: true offset is count minus six high-speed periods.
// RULE14: Software keeps timebase roughly 8 to 1000 times faster than A and B.
// RULE15: At ratio up to 1023, result equal to B period means aligned.
// RULE16: At ratio 1024 to 2047 aligned signals overflow; inverted B remeasure gives half.
// RULE17: Latched ready and overflow flags clear when software writes one.
// RULE18: Above ratio 2047 software shifts a signal, remeasures, then shifts back.
// RULE19: Overflow flag stays until cleared; start clears counters before counting.
package pom_pkg;
  localparam int          POM_RES_W      = 11;
  localparam int          POM_SEL_W      = 5;
  localparam int          POM_TB_SEL_W   = 3;
  localparam int          POM_NUM_TB     = 5;
  // Source map: clock inputs, then clock outputs, then pins
  localparam int          POM_NUM_IN     = 4;
  localparam int          POM_NUM_OUT    = 6;
  localparam int          POM_NUM_PIN    = 8;
  localparam int          POM_OUT_BASE   = 16;
  localparam int          POM_PIN_BASE   = 24;
  localparam int          POM_NUM_SRC    = 32;
  localparam int          POM_HS_PERIODS = 6;
  localparam int          POM_CORR_W     = 4;
  localparam logic [10:0] POM_CNT_MAX    = 11'h3ff;
  localparam logic [10:0] POM_CNT_ZERO   = 11'h000;
  localparam logic [10:0] POM_CNT_ONE    = 11'h001;
  localparam logic [3:0]  POM_CORR_POS   = 4'h6;
  localparam logic [3:0]  POM_CORR_NEG   = 4'ha;
  localparam logic [3:0]  POM_CORR_NONE  = 4'h0;

  typedef enum logic [2:0] {
    POM_IDLE   = 3'b001,
    POM_WAIT_A = 3'b010,
    POM_COUNT  = 3'b100
  } pom_state_t;
endpackage

// ===== sim/tb_top.sv
// Self-checking bench for the phase offset measurement block.
// Drives every port itself; timebase ticks and A/B levels come from the bench.
`timescale 1ns/1ns
module tb_top;
  import pom_pkg::*;
  logic        clk_i    = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        inv      = 1'b0;
  logic        start_i  = 1'b0;
  logic        rst_m    = 1'b0;
  logic        rclr     = 1'b0;
  logic        oclr     = 1'b0;
  logic [31:0] src      = 32'h0;
  logic [4:0]  tbs      = 5'h0;
  logic [4:0]  asel     = 5'h0;
  logic [4:0]  bsel     = 5'h0;
  logic [2:0]  tsel     = 3'h0;
  logic [10:0] last_e   = 11'h0;
  logic        busy;
  logic        rdy;
  logic        ovf;
  logic [10:0] cnt;
  logic [3:0]  corr;
  int          n_fail      = 0;
  int          check_count = 0;

  pom_phase_offset_measure dut_u (
    .clk_i                  (clk_i),
    .arst_n_i               (arst_n_i),
    .src_vec_i              (src),
    .tb_src_i               (tbs),
    .first_signal_select_i  (asel),
    .second_signal_select_i (bsel),
    .timebase_select_i      (tsel),
    .second_edge_invert_i   (inv),
    .start_i                (start_i),
    .offset_count_reset_i           (rst_m),
    .ready_clear_i          (rclr),
    .overflow_clear_i       (oclr),
    .busy_o                 (busy),
    .result_ready_latched_o (rdy),
    .overflow_latched_o     (ovf),
    .offset_count_o         (cnt),
    .offset_correction_o    (corr)
  );

  always #5 clk_i = ~clk_i;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input logic [10:0] seen, input logic [10:0] exp, input string nm);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // B level per tick; p of zero means B never toggles
  function automatic logic blv(int i, int tb, int p);
    return p > 0 && i >= tb && ((i - tb) % p) < p / 2;
  endfunction

  function automatic logic edg(int i, int tb, int p, logic v);
    logic c = blv(i, tb, p);
    logic o = blv(i - 1, tb, p);
    return v ? (o && !c) : (c && !o);
  endfunction

  // Nearest earlier B edge wins if closer than the forward one
  function automatic int expv(int ta, int tb, int p, logic v);
    int lst = -1;
    int f   = 0;
    for (int i = 1; i < ta; i++) if (edg(i, tb, p, v)) lst = i;
    for (int i = ta + 1; i < ta + 1023 && f == 0; i++) if (edg(i, tb, p, v)) f = i - ta;
    if (f == 0) return 9999;
    if (lst >= 0 && ta - lst < f) return lst - ta;
    return f;
  endfunction

  task automatic offset_count(input int ta, tb, p, t, input logic [4:0] a, b, input logic v,
                      input logic [3:0] ec);
    int e;
    e = expv(ta, tb, p, v);
    asel = a;
    bsel = b;
    tsel = t[2:0];
    inv = v;
    src = 32'h0;
    tbs = 5'h0;
    cyc(2);
    start_i = 1'b1;
    cyc(1);
    start_i = 1'b0;
    chk(busy, 11'h1, "busy start");
    for (int i = 0; i < 1200 && busy === 1'b1; i++) begin
      src[a] = (i >= ta);
      src[b] = blv(i, tb, p);
      tbs[t] = 1'b0;
      cyc(2);
      tbs[t] = 1'b1;
      cyc(2);
    end
    chk(busy, 11'h0, "busy end");
    chk(rdy, 11'h1, "ready");
    chk(ovf, {10'h0, e > 2000}, "overflow");
    if (e > 2000) begin
      chk(cnt, last_e, "count kept");
    end else begin
      last_e = e[10:0];
      chk(cnt, last_e, "count");
      chk(corr, ec, "correction");
    end
    rclr = 1'b1;
    oclr = 1'b1;
    cyc(1);
    rclr = 1'b0;
    oclr = 1'b0;
    cyc(1);
    chk({rdy, ovf}, 11'h0, "flags cleared");
  endtask

  task automatic final_report();
    if (n_fail == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    cyc(10);
    arst_n_i = 1'b1;
    cyc(1);
    offset_count(3, 5, 8, 0, 5'd24, 5'd16, 1'b0, 4'h6);
    offset_count(4, 4, 6, 1, 5'd17, 5'd1, 1'b0, 4'ha);
    offset_count(6, 3, 10, 2, 5'd2, 5'd0, 1'b0, 4'h0);
    offset_count(3, 2, 8, 3, 5'd25, 5'd31, 1'b1, 4'h0);
    offset_count(2, 0, 0, 4, 5'd18, 5'd19, 1'b0, 4'h0);
    // Abort mid-count, then a clean run must still work
    start_i = 1'b1;
    cyc(1);
    start_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
      src[asel] = (i >= 1);
      tbs[4] = 1'b0;
      cyc(2);
      tbs[4] = 1'b1;
      cyc(2);
    end
    rst_m = 1'b1;
    cyc(1);
    rst_m = 1'b0;
    cyc(1);
    chk({busy, rdy}, 11'h0, "abort");
    offset_count(3, 5, 8, 0, 5'd24, 5'd16, 1'b0, 4'h6);
    final_report();
  end

  // Longest run is the overflow case, about 41 us
  initial begin
    #300000;
    n_fail++;
    final_report();
  end
endmodule
